// >>> hdl/sep_eeprom.sv
// Two-wire serial EEPROM slave: protocol engine, page latches and array
// ==========================================================
`timescale 1ns/1ns

module sep_eeprom #(
   parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES,
   parameter logic [3:0] DEV_TYPE = sep_pkg::DEV_TYPE_DEF // Arbitrary value
) (
   input wire logic clk_i, // Core clock, 20 MHz
   input wire logic nrst_i, // Synchronous reset, active low
   input wire logic scl_clk_i, // Serial clock from the master
   input wire logic sda_i, // Serial data line level
   output logic sda_o, // Serial data drive value
   output logic sda_oe_o, // Pull serial data low when high
   input wire sep_pkg::sep_strap_s strap_i, // Select straps and write lock
   output logic busy_o, // Programming cycle running
   output logic live_o // Power-up hold has passed
);
   import sep_pkg::*;

   // Refuse a programming time that the timer cannot hold
   if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TIMER_W)) begin : g_bad_prog
      $error("PROG_CYCLES out of range");
   end

   // ==========================================================
   // Link domain
   // sample on rise
   logic rx_r;
   always_ff @(posedge scl_clk_i) begin
      rx_r <= sda_i;
   end

   // ==========================================================
   // Core domain state
   sep_core_s q;
   sep_core_s d;
   logic [7:0] mem [MEM_BYTES];
   logic rise_w;
   logic fall_w;
   logic start_w;
   logic stop_w;
   logic match_w;
   logic prog_ok_w;
   logic [7:0] byte_w;
   logic [7:0] rdata_w;

   always_ff @(posedge clk_i) begin
      if (q.busy && !q.pidx[4] && q.mask[q.pidx[3:0]]) begin
         mem[{q.addr[ADDR_W-1:PAGE_W], q.pidx[3:0]}] <= q.lat[q.pidx[3:0]];
      end
   end

   // Next state of the whole core
   always_comb begin
      d = q;
      d.st_m = strap_i;
      d.st_s = q.st_m;
      d.scl_m = scl_clk_i;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_i;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      rise_w = q.scl_s && !q.scl_p;
      fall_w = !q.scl_s && q.scl_p;
      start_w = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
      stop_w = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
      byte_w = {q.shreg[6:0], rx_r};
      rdata_w = mem[q.addr];
      match_w = (byte_w[7:4] == DEV_TYPE) && (byte_w[3] == q.st_s.cs_two)
         && (byte_w[2] == q.st_s.cs_one);
      prog_ok_w = (q.state == ST_DATA) && (q.dcnt != 5'h00) && (q.cnt == CNT_STOP);

      if (q.busy) begin
         if (!q.pidx[4]) begin
            d.pidx = q.pidx + 5'h01;
         end
         if (q.timer == '0) begin
            d.busy = 1'b0;
         end else begin
            d.timer = q.timer - TIMER_W'(1);
         end
      end

      if (!q.live) begin
         if (q.por == POR_W'(POR_HOLD_CYCLES)) begin
            d.live = 1'b1;
         end else begin
            d.por = q.por + POR_W'(1);
         end
      end else if (start_w) begin
         d.state = ST_ADDR;
         d.cnt = 4'h0;
         d.oe = 1'b0;
         d.ackgo = 1'b0;
      end else if (stop_w) begin
         if (prog_ok_w && !q.st_s.wlock && !q.busy) begin
            d.busy = 1'b1;
            d.timer = TIMER_W'(PROG_CYCLES - 1); // timed from stop
            d.pidx = 5'h00;
         end
         d.state = ST_IDLE;
         d.oe = 1'b0;
         d.ackgo = 1'b0;
      end else if (rise_w && q.state != ST_IDLE && q.state != ST_SKIP) begin
         d.cnt = q.cnt + 4'h1;
         if (q.state != ST_READ && q.cnt < CNT_ACK) begin
            d.shreg = byte_w;
         end
         if (q.cnt == CNT_LAST) begin
            case (q.state)
               ST_ADDR: begin
                  if (match_w && !q.busy) begin
                     d.ackgo = 1'b1;
                     d.rd = byte_w[0];
                     d.msb = byte_w[1];
                  end else begin
                     d.state = ST_SKIP;
                  end
               end
               ST_WORD: begin
                  d.addr = {q.msb, byte_w};
                  d.dcnt = 5'h00;
                  d.mask = '0;
                  d.ackgo = 1'b1;
               end
               ST_DATA: begin
                  d.lat[q.addr[3:0]] = byte_w;
                  d.mask[q.addr[3:0]] = 1'b1;
                  d.addr[3:0] = q.addr[3:0] + 4'h1;
                  if (q.dcnt != DCNT_MAX) begin
                     d.dcnt = q.dcnt + 5'h01;
                  end
                  d.ackgo = 1'b1;
               end
               ST_READ: begin
                  d.addr = q.addr + ADDR_W'(1);
               end
               default: begin
                  d.ackgo = 1'b0;
               end
            endcase
         end
         if (q.cnt == CNT_ACK && q.state == ST_READ && rx_r) begin
            d.state = ST_SKIP;
         end
      end else if (fall_w && q.state != ST_IDLE && q.state != ST_SKIP) begin
         if (q.cnt == CNT_ACK) begin
            d.oe = q.ackgo;
            d.ackgo = 1'b0;
         end else if (q.cnt == CNT_DONE) begin
            d.cnt = 4'h0;
            d.oe = 1'b0;
            case (q.state)
               ST_ADDR: d.state = q.rd ? ST_READ : ST_WORD;
               ST_WORD: d.state = ST_DATA;
               default: d.state = q.state;
            endcase
            if (q.state == ST_READ || (q.state == ST_ADDR && q.rd)) begin
               d.shreg = rdata_w;
               d.oe = !rdata_w[7];
            end
         end else if (q.state == ST_READ && q.cnt != 4'h0 && q.cnt < CNT_ACK) begin
            d.oe = !q.shreg[3'(CNT_LAST - q.cnt)];
         end
      end
   end

   // Register the core state
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Pin and status outputs
   assign sda_o = 1'b0; // Open drain only pulls low
   assign sda_oe_o = q.oe;
   assign busy_o = q.busy;
   assign live_o = q.live;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   start_addr_a: assert property (q.live && start_w |=> q.state == ST_ADDR && !q.oe)
      else $error("start did not enter address phase");

   stop_idle_a: assert property (q.live && !start_w && stop_w |=> q.state == ST_IDLE)
      else $error("stop did not return to standby");

   busy_nack_a: assert property (q.busy && q.state == ST_ADDR && rise_w && q.cnt == CNT_LAST
      |=> !q.ackgo && q.state == ST_SKIP)
      else $error("acknowledge armed while programming");

   cs_match_a: assert property (q.state == ST_ADDR && rise_w && q.cnt == CNT_LAST && !start_w
      && !stop_w && byte_w[3:2] != {q.st_s.cs_two, q.st_s.cs_one} |=> !q.ackgo)
      else $error("acknowledge armed for another device");

   lock_block_a: assert property ($rose(q.busy) |-> !$past(q.st_s.wlock))
      else $error("programming started while locked");

   prog_start_a: assert property ($rose(q.busy) |-> $past(stop_w) && $past(q.cnt) == CNT_STOP
      && $past(q.state) == ST_DATA)
      else $error("programming started without valid stop");

   prog_time_a: assert property ($rose(q.busy) |-> q.timer == TIMER_W'(PROG_CYCLES - 1))
      else $error("programming time not loaded");

   busy_quiet_a: assert property (q.busy |-> q.state != ST_WORD && q.state != ST_DATA)
      else $error("write phase accepted while busy");

   page_wrap_a: assert property (q.state == ST_DATA && rise_w && q.cnt == CNT_LAST
      && !start_w && !stop_w |=> q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W]))
      else $error("page write crossed a page");

   read_wrap_a: assert property (q.state == ST_READ && rise_w && q.cnt == CNT_LAST
      && !start_w && !stop_w && q.addr == '1 |=> q.addr == '0)
      else $error("read counter did not wrap");

   oe_edge_a: assert property ($changed(q.oe) |-> $past(fall_w || start_w || stop_w))
      else $error("data drive changed off a falling edge");

   por_quiet_a: assert property (!q.live |-> !q.oe && q.state == ST_IDLE)
      else $error("response during power-up hold");

endmodule

// >>> hdl/sep_pkg.sv
// Shared constants, types and state layout of the serial EEPROM slave
package sep_pkg;

   // ==========================================================
   // Array geometry
   localparam int MEM_BYTES = 512;
   localparam int PAGES = 32;
   localparam int PAGE_BYTES = 16;
   localparam int ADDR_W = 9;
   localparam int PAGE_W = 4;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int PROG_TIME_MS = 10;
   // Longest time, so the division rounds down
   localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
   localparam int TIMER_W = 18;
   localparam int POR_HOLD_CYCLES = 16;
   localparam int POR_W = 5;

   // ==========================================================
   // Bit counter values (rising SCL edges seen in the current byte), data byte count limit and default type code
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [3:0] CNT_DONE = 4'h9;
   localparam logic [3:0] CNT_STOP = 4'h1;
   localparam logic [4:0] DCNT_MAX = 5'h10;
   localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_WORD = 3'h3,
      ST_DATA = 3'h2,
      ST_READ = 3'h6,
      ST_SKIP = 3'h7
   } sep_state_e;

   typedef struct packed {
      logic cs_two;
      logic cs_one;
      logic wlock;
   } sep_strap_s;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      sep_strap_s st_m;
      sep_strap_s st_s;
      logic [POR_W-1:0] por;
      logic live;
      sep_state_e state;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic rd;
      logic msb;
      logic ackgo;
      logic oe;
      logic [ADDR_W-1:0] addr;
      logic [4:0] dcnt;
      logic [PAGE_BYTES-1:0][7:0] lat;
      logic [PAGE_BYTES-1:0] mask;
      logic busy;
      logic [TIMER_W-1:0] timer;
      logic [4:0] pidx;
   } sep_core_s;

endpackage

// >>> testbench/sep_mst_model.sv
// Bus master model driving the serial clock and data line
`timescale 1ns/1ns

module sep_mst_model (
   input wire logic sda_i, // Resolved data line level
   output logic scl_o, // Serial clock, stands high between frames
   output logic sda_low_o // Pulls the data line low when high
);
   logic lclk = 1'b0;

   // Idle bus, nothing pulled
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Link timebase, 15 ns period
   always begin
      #7 lclk = 1'b1;
      #8 lclk = 1'b0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge lclk);
   endtask

   // data moves only while clock low
   task automatic bit_x(input logic b, output logic r);
      sda_low_o <= ~b;
      tk(10);
      scl_o <= 1'b1;
      tk(10);
      r = sda_i;
      tk(10);
      scl_o <= 1'b0;
      tk(20);
   endtask

   // start, data falls with clock high
   task automatic start();
      sda_low_o <= 1'b0;
      tk(10);
      scl_o <= 1'b1;
      tk(20);
      sda_low_o <= 1'b1;
      tk(20);
      scl_o <= 1'b0;
      tk(20);
   endtask

   // stop, data rises with clock high
   task automatic stop();
      sda_low_o <= 1'b1;
      tk(10);
      scl_o <= 1'b1;
      tk(20);
      sda_low_o <= 1'b0;
      tk(20);
   endtask

   // byte out, msb first, ack on ninth clock
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   // byte in, master ack or nack on ninth clock
   task automatic rd(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(~ack, r);
   endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the serial EEPROM slave
`timescale 1ns/1ns

module tb_top;
   import sep_pkg::*;
   localparam int PRG = 400;
   localparam logic [3:0] DT = 4'h5; // Arbitrary type code
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   sep_strap_s strap_i = '0;
   logic scl, low, sda_o, sda_oe_o, busy_o, live_o, ack;
   logic [7:0] d;
   logic [7:0] sh [512];
   int err_count = 0;
   int checked = 0;
   // Open-drain wire with pull-up
   wire sda = ~(low | sda_oe_o);
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end

   always #25 clk_i = ~clk_i;

   sep_mst_model u_mst (.sda_i(sda), .scl_o(scl), .sda_low_o(low));
   sep_eeprom #(.PROG_CYCLES(PRG), .DEV_TYPE(DT)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .strap_i(strap_i), .busy_o(busy_o), .live_o(live_o));

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Address byte, then the word byte when asked
   task automatic adr(input logic [8:0] a, input logic rw, input logic e, input logic w);
      u_mst.start();
      u_mst.wr({DT, 2'b10, a[8], rw}, ack);
      `CHK(ack, e, "address ack")
      if (w) begin
         u_mst.wr(a[7:0], ack);
         `CHK(ack, 1'b1, "word ack")
      end
   endtask

   task automatic wd(input logic [7:0] v);
      u_mst.wr(v, ack);
      `CHK(ack, 1'b1, "data ack")
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_o !== 1'b0) begin
         @(posedge clk_i);
         n++;
         if (n > 2 * PRG) begin
            `CHK(1'b1, 1'b0, "busy timeout")
            give_verdict();
         end
      end
   endtask

   // Programming cycle: one nacked poll while busy, wait for busy_o to fall, then one acked poll
   task automatic prog(input logic m);
      time t0;
      t0 = $time;
      repeat (3) @(posedge clk_i);
      `CHK(busy_o, 1'b1, "busy after stop")
      adr({m, 8'h00}, 1'b0, 1'b0, 1'b0);
      u_mst.stop();
      wait_idle();
      `CHK(($time - t0) <= PRG * 50 + 200, 1'b1, "program time")
      adr({m, 8'h00}, 1'b0, 1'b1, 1'b0);
      u_mst.stop();
   endtask

   task automatic s_reset();
      int n;
      repeat (5) @(posedge clk_i);
      `CHK({live_o, busy_o, sda_oe_o}, 3'b000, "reset outputs")
      `CHK(sda_o, 1'b0, "open drain value")
      nrst_i <= 1'b1;
      strap_i <= '{cs_two: 1'b1, cs_one: 1'b0, wlock: 1'b0};
      n = 0;
      while (live_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(n >= 15 && n < 40, 1'b1, "power-up hold")
   endtask

   task automatic s_select();
      u_mst.start();
      u_mst.wr({DT, 2'b01, 2'b00}, ack);
      `CHK(ack, 1'b0, "select mismatch")
      u_mst.start();
      u_mst.wr({~DT, 2'b10, 2'b00}, ack);
      `CHK(ack, 1'b0, "type mismatch")
      u_mst.stop();
   endtask

   task automatic s_write();
      adr(9'h000, 1'b0, 1'b1, 1'b1);
      wd(8'h5a);
      u_mst.stop();
      sh[0] = 8'h5a;
      prog(1'b0);
      adr(9'h1f8, 1'b0, 1'b1, 1'b1);
      for (int k = 0; k < 18; k++) begin
         wd(8'h30 + 8'(k));
         sh[9'h1f0 | 9'((8 + k) % 16)] = 8'h30 + 8'(k);
      end
      u_mst.stop();
      prog(1'b1);
      u_mst.start();
      u_mst.wr({DT, 2'b10, 2'b01}, ack);
      `CHK(ack, 1'b1, "read address ack")
      u_mst.rd(1'b0, d);
      `CHK(d, sh[9'h1fa], "current read")
      u_mst.stop();
   endtask

   task automatic s_guard();
      @(posedge clk_i);
      strap_i <= '{cs_two: 1'b1, cs_one: 1'b0, wlock: 1'b1};
      adr(9'h000, 1'b0, 1'b1, 1'b1);
      wd(8'hc3);
      u_mst.stop();
      wait_idle();
      @(posedge clk_i);
      strap_i <= '{cs_two: 1'b1, cs_one: 1'b0, wlock: 1'b0};
      adr(9'h000, 1'b0, 1'b1, 1'b1);
      wd(8'h99);
      u_mst.bit_x(1'b1, ack);
      u_mst.stop();
      repeat (5) @(posedge clk_i);
      `CHK(busy_o, 1'b0, "late stop")
   endtask

   task automatic s_read();
      adr(9'h1ff, 1'b0, 1'b1, 1'b1);
      u_mst.start();
      u_mst.wr({DT, 2'b10, 2'b01}, ack);
      `CHK(ack, 1'b1, "read address ack")
      u_mst.rd(1'b1, d);
      `CHK(d, sh[9'h1ff], "random read")
      u_mst.rd(1'b0, d);
      `CHK(d, sh[9'h000], "wrap read")
      repeat (8) @(posedge clk_i);
      `CHK(sda_oe_o, 1'b0, "released after nack")
      u_mst.stop();
   endtask

   // Main sequence
   initial begin
      s_reset();
      s_select();
      s_write();
      s_guard();
      s_read();
      give_verdict();
   end
endmodule
